// ==== hdl/pdr_pkg.sv ====
// Purpose: Shared constants and types of the pump dry-run monitor
// Assumes: 50 MHz control clock, AHB-Lite register access, 32-bit words
// Notes: Power in 0.01 kW steps, speed in 0.1 Hz steps, delays in seconds
package pdr_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_MODE = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_POWER_EST = 8'h08;
    localparam logic [7:0] OFS_LOW_POWER = 8'h0C;
    localparam logic [7:0] OFS_LOW_SPEED = 8'h10;
    localparam logic [7:0] OFS_HIGH_POWER = 8'h14;
    localparam logic [7:0] OFS_HIGH_SPEED = 8'h18;
    localparam logic [7:0] OFS_FACTOR = 8'h1C;
    localparam logic [7:0] OFS_ERR_DELAY = 8'h20;
    localparam logic [7:0] OFS_RESTART_DELAY = 8'h24;
    localparam logic [7:0] OFS_SWITCH_SEL = 8'h28;
    // Status fields
    localparam int STS_WARN_BIT = 0;
    localparam int STS_ERR_BIT = 1;
    localparam int STS_INHIBIT_BIT = 2;
    // Switch selector fields: index 1..6, group, level
    localparam int SEL_EXT_BIT = 3;
    localparam int SEL_LOW_BIT = 4;
    localparam logic [2:0] SEL_IDX_MAX = 3'h6;
    // Ranges and reset values
    localparam logic [14:0] POWER_MAX = 15'h7FFF;
    localparam logic [15:0] LOW_SPEED_MAX = 16'h1388;
    localparam logic [15:0] SPEED_RST = 16'h0000;
    localparam logic [14:0] POWER_RST = 15'h0000;
    localparam logic [6:0] FACTOR_MAX = 7'h64;
    localparam logic [6:0] FACTOR_RST = 7'h46;
    localparam logic [11:0] ERR_DELAY_MAX = 12'hE10;
    localparam logic [11:0] ERR_DELAY_RST = 12'h005;
    localparam logic [11:0] RESTART_MIN = 12'h00A;
    localparam logic [11:0] RESTART_MAX = 12'hE10;
    localparam logic [11:0] RESTART_RST = 12'h03C;
    localparam logic [6:0] PERCENT_SCALE = 7'h64;
    // Timing
    localparam int CLK_HZ = 50_000_000;
    localparam int SEC_TICK_S = 1;
    localparam int SEC_CYCLES = SEC_TICK_S * CLK_HZ;

    typedef enum logic [1:0] {
        MODE_OFF = 2'h0,
        MODE_SWITCH = 2'h1,
        MODE_POWER = 2'h2
    } pdr_mode_e;

    typedef struct packed {
        logic [5:0] base;
        logic [5:0] ext;
        logic extPresent;
    } pdr_inputs_s;

    typedef struct packed {
        logic warning;
        logic error;
        logic restartInhibit;
    } pdr_status_s;
endpackage

// ==== hdl/pdr_dry_run_monitor.sv ====
// Purpose: Pump dry-run detection by flow switch or no-flow power curve
// Assumes: Inputs synchronous to sys_clk; estimates refreshed by the drive
// Notes: Delays run on a free one-second tick, so they resolve to +/-1 s
`timescale 1ns/100ps

// Notes on behaviour
// - Mode selector: disabled by default, switch input, or sensorless power.
// - In switch mode a high level on the chosen input means dry run.
// - Selector picks none or one base/extension input, optionally inverted.
// - Extension inputs count only when the extension module is present.
// - Power mode flags dry run when power is below curve times factor.
// - The no-flow curve has exactly two points: low and high speed.
// - Factor is a percentage 0 to 100, default 70.
// - Curve powers 0.00 to 327.67 kW in 0.01 kW, default zero.
// - Curve speeds in 0.1 Hz, default zero; low speed up to 500.0 Hz.
// - Signed mechanical power estimate is readable, -327.68 to 327.67 kW.
// - Warning stays asserted while the dry-run condition is present.
// - Error raised once condition lasts longer than the error delay.
// - Error delay 0 to 3600 s, default 5 s.
// - After an error, restart blocked until restart delay ends, even if cleared.
// - Restart delay 10 to 3600 s, default 60 s.
// - Error and restart inhibit are not kept across power-off.
// - Delays usable unless disabled; curve only in power; selector only in switch.
module pdr_dry_run_monitor #(
    parameter int unsigned SEC_CYCLES = pdr_pkg::SEC_CYCLES
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Drive side
    input wire pdr_pkg::pdr_inputs_s digIn,
    input wire logic signed [15:0] powerEst,
    input wire logic [15:0] speedEst,
    output pdr_pkg::pdr_status_s status
);
    import pdr_pkg::*;

    logic rstMeta_r, rstSync_r;
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rstMeta_r <= 1'b0;
            rstSync_r <= 1'b0;
        end else begin
            rstMeta_r <= 1'b1;
            rstSync_r <= rstMeta_r;
        end
    end
    wire logic rstn = rstSync_r;

    // Configuration
    pdr_mode_e mode_r;
    logic [4:0] switchSel_r;
    logic [14:0] lowPower_r, highPower_r;
    logic [15:0] lowSpeed_r, highSpeed_r;
    logic [6:0] factor_r;
    logic [11:0] errDelay_r, restartDelay_r;
    logic signed [15:0] powerEst_r;
    logic warn_r, error_r;
    logic [11:0] errCnt_r, restartCnt_r;

    // AHB address phase capture
    logic wrPend_r;
    logic [7:0] wrAddr_r;
    wire logic addrPhase = hsel && htrans[1] && hready;
    wire logic wrStb = wrPend_r;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    function automatic logic [11:0] clampU12(input logic [31:0] v, input logic [11:0] lo,
                                             input logic [11:0] hi);
        if (v > {20'h0, hi}) begin
            return hi;
        end else if (v < {20'h0, lo}) begin
            return lo;
        end
        return v[11:0];
    endfunction

    function automatic logic selValid(input logic [4:0] sel, input logic extOk);
        return (sel[2:0] != 3'h0) && (sel[2:0] <= SEL_IDX_MAX) && (!sel[SEL_EXT_BIT] || extOk);
    endfunction

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            wrPend_r <= 1'b0;
            wrAddr_r <= 8'h00;
        end else begin
            wrPend_r <= addrPhase && hwrite;
            wrAddr_r <= haddr;
        end
    end

    wire logic modeSwitch = (mode_r == MODE_SWITCH);
    wire logic modePower = (mode_r == MODE_POWER);
    wire logic modeOn = (mode_r != MODE_OFF);

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            mode_r <= MODE_OFF;
            switchSel_r <= 5'h00;
            lowPower_r <= POWER_RST;
            highPower_r <= POWER_RST;
            lowSpeed_r <= SPEED_RST;
            highSpeed_r <= SPEED_RST;
            factor_r <= FACTOR_RST;
            errDelay_r <= ERR_DELAY_RST;
            restartDelay_r <= RESTART_RST;
        end else if (wrStb) begin
            unique case (wrAddr_r)
                OFS_MODE: begin
                    if (hwdata[1:0] != 2'h3) begin
                        mode_r <= pdr_mode_e'(hwdata[1:0]);
                    end
                end
                OFS_SWITCH_SEL: begin
                    if (modeSwitch) begin
                        switchSel_r <= hwdata[4:0];
                    end
                end
                OFS_LOW_POWER: begin
                    if (modePower) begin
                        lowPower_r <= hwdata[15] ? POWER_MAX : hwdata[14:0];
                    end
                end
                OFS_HIGH_POWER: begin
                    if (modePower) begin
                        highPower_r <= hwdata[15] ? POWER_MAX : hwdata[14:0];
                    end
                end
                OFS_LOW_SPEED: begin
                    if (modePower) begin
                        lowSpeed_r <= (hwdata[15:0] > LOW_SPEED_MAX) ? LOW_SPEED_MAX
                                                                     : hwdata[15:0];
                    end
                end
                OFS_HIGH_SPEED: begin
                    if (modePower) begin
                        highSpeed_r <= hwdata[15:0];
                    end
                end
                OFS_FACTOR: begin
                    if (modePower) begin
                        factor_r <= (hwdata[7:0] > {1'b0, FACTOR_MAX}) ? FACTOR_MAX
                                                                       : hwdata[6:0];
                    end
                end
                OFS_ERR_DELAY: begin
                    if (modeOn) begin
                        errDelay_r <= clampU12(hwdata, 12'h000, ERR_DELAY_MAX);
                    end
                end
                OFS_RESTART_DELAY: begin
                    if (modeOn) begin
                        restartDelay_r <= clampU12(hwdata, RESTART_MIN, RESTART_MAX);
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // Read mux; settings not available in the present mode read as zero
    logic [31:0] rdVal;
    always_comb begin
        rdVal = 32'h0000_0000;
        unique case (haddr)
            OFS_MODE: rdVal = {30'h0, mode_r};
            OFS_STATUS: rdVal = {29'h0, status.restartInhibit, error_r, warn_r};
            OFS_POWER_EST: rdVal = {{16{powerEst_r[15]}}, powerEst_r};
            OFS_SWITCH_SEL: rdVal = modeSwitch ? {27'h0, switchSel_r} : 32'h0;
            OFS_LOW_POWER: rdVal = modePower ? {17'h0, lowPower_r} : 32'h0;
            OFS_HIGH_POWER: rdVal = modePower ? {17'h0, highPower_r} : 32'h0;
            OFS_LOW_SPEED: rdVal = modePower ? {16'h0, lowSpeed_r} : 32'h0;
            OFS_HIGH_SPEED: rdVal = modePower ? {16'h0, highSpeed_r} : 32'h0;
            OFS_FACTOR: rdVal = modePower ? {25'h0, factor_r} : 32'h0;
            OFS_ERR_DELAY: rdVal = modeOn ? {20'h0, errDelay_r} : 32'h0;
            OFS_RESTART_DELAY: rdVal = modeOn ? {20'h0, restartDelay_r} : 32'h0;
            default: rdVal = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            hrdata <= 32'h0000_0000;
        end else if (addrPhase && !hwrite) begin
            hrdata <= rdVal;
        end
    end

    // Switch detection
    logic switchDry;
    always_comb begin
        logic [5:0] grp;
        grp = switchSel_r[SEL_EXT_BIT] ? digIn.ext : digIn.base;
        switchDry = selValid(switchSel_r, digIn.extPresent)
                    && (grp[switchSel_r[2:0] - 3'h1] ^ switchSel_r[SEL_LOW_BIT]);
    end

    // Power curve check; cross-multiplied so no divider is needed
    logic [15:0] spanSpd, offSpd;
    logic signed [47:0] lhs, rhs;
    logic powerDry_r;
    always_comb begin
        if (highSpeed_r > lowSpeed_r) begin
            spanSpd = highSpeed_r - lowSpeed_r;
            if (speedEst <= lowSpeed_r) begin
                offSpd = 16'h0000;
            end else if (speedEst >= highSpeed_r) begin
                offSpd = spanSpd;
            end else begin
                offSpd = speedEst - lowSpeed_r;
            end
        end else begin
            spanSpd = 16'h0001;
            offSpd = 16'h0000;
        end
        lhs = {{32{powerEst_r[15]}}, powerEst_r} * {41'h0, PERCENT_SCALE}
              * {32'h0, spanSpd};
        rhs = {41'h0, factor_r} * ({33'h0, lowPower_r} * {32'h0, spanSpd}
              + ({33'h0, highPower_r} - {33'h0, lowPower_r}) * {32'h0, offSpd});
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            powerEst_r <= 16'sh0000;
            powerDry_r <= 1'b0;
        end else begin
            powerEst_r <= powerEst;
            powerDry_r <= lhs < rhs;
        end
    end

    wire logic dryCond = (modeSwitch && switchDry) || (modePower && powerDry_r);

    // One-second tick
    logic [31:0] tickCnt_r;
    logic secTick;
    assign secTick = (tickCnt_r == 32'(SEC_CYCLES - 1));
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            tickCnt_r <= 32'h0000_0000;
        end else begin
            tickCnt_r <= secTick ? 32'h0000_0000 : tickCnt_r + 32'h0000_0001;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            warn_r <= 1'b0;
        end else begin
            warn_r <= dryCond;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            errCnt_r <= 12'h000;
        end else if (!dryCond) begin
            errCnt_r <= 12'h000;
        end else if (secTick && errCnt_r != 12'hFFF) begin
            errCnt_r <= errCnt_r + 12'h001;
        end
    end

    // Set beats a simultaneous software clear
    wire logic errSet = dryCond && secTick && (errCnt_r >= errDelay_r);
    wire logic errClr = wrStb && (wrAddr_r == OFS_STATUS) && hwdata[STS_ERR_BIT];
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            error_r <= 1'b0;
        end else if (errSet) begin
            error_r <= 1'b1;
        end else if (errClr) begin
            error_r <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            restartCnt_r <= 12'h000;
        end else if (errSet) begin
            restartCnt_r <= restartDelay_r;
        end else if (secTick && restartCnt_r != 12'h000) begin
            restartCnt_r <= restartCnt_r - 12'h001;
        end
    end

    assign status.warning = warn_r;
    assign status.error = error_r;
    assign status.restartInhibit = error_r || (restartCnt_r != 12'h000);

    a_warn_follows: assert property (@(posedge sys_clk) disable iff (!rstn)
        warn_r == $past(dryCond)) else $error("warning not tracking condition");
    a_timer_clears: assert property (@(posedge sys_clk) disable iff (!rstn)
        !dryCond |=> errCnt_r == 12'h000) else $error("error timer kept");
    a_err_needs_time: assert property (@(posedge sys_clk) disable iff (!rstn)
        $rose(error_r) |-> $past(errCnt_r) >= $past(errDelay_r) && $past(dryCond))
        else $error("error raised early");
    a_err_sets: assert property (@(posedge sys_clk) disable iff (!rstn)
        errSet |=> error_r && restartCnt_r == $past(restartDelay_r))
        else $error("error not raised");
    a_inhibit_hold: assert property (@(posedge sys_clk) disable iff (!rstn)
        $fell(status.restartInhibit) |-> $past(restartCnt_r) <= 12'h001)
        else $error("restart allowed during delay");
    a_factor_range: assert property (@(posedge sys_clk) disable iff (!rstn)
        factor_r <= FACTOR_MAX) else $error("factor out of range");
    a_err_delay_range: assert property (@(posedge sys_clk) disable iff (!rstn)
        errDelay_r <= ERR_DELAY_MAX) else $error("error delay out of range");
    a_restart_range: assert property (@(posedge sys_clk) disable iff (!rstn)
        restartDelay_r >= RESTART_MIN && restartDelay_r <= RESTART_MAX)
        else $error("restart delay out of range");
    a_off_quiet: assert property (@(posedge sys_clk) disable iff (!rstn)
        mode_r == MODE_OFF |=> !warn_r) else $error("warning while disabled");
    a_ext_absent: assert property (@(posedge sys_clk) disable iff (!rstn)
        modeSwitch && switchSel_r[SEL_EXT_BIT] && !digIn.extPresent |=> !warn_r)
        else $error("extension input used while absent");
    a_curve_gated: assert property (@(posedge sys_clk) disable iff (!rstn)
        !modePower |=> $stable(factor_r) && $stable(lowPower_r))
        else $error("curve written outside power mode");

    c_switch_err: cover property (@(posedge sys_clk) disable iff (!rstn)
        modeSwitch && $rose(error_r));
    c_power_warn: cover property (@(posedge sys_clk) disable iff (!rstn)
        modePower && $rose(warn_r));
    c_inhibit_end: cover property (@(posedge sys_clk) disable iff (!rstn)
        $fell(status.restartInhibit));
endmodule

// ==== sim/pdr_drive_model.sv ====
// Purpose: Drive-side model of the flow switch wiring and the power/speed estimator
// Assumes: Bench commands flow state, switch position and estimates
// Notes: Unused inputs show the opposite level, so a wrong pick shows up
`timescale 1ns/100ps
module pdr_drive_model (
    // Clock
    input wire logic sys_clk,
    // Commands from the bench
    input wire logic flowOk,
    input wire logic [3:0] swPos,
    input wire logic extFitted,
    input wire logic signed [15:0] pwrCmd,
    input wire logic [15:0] spdCmd,
    // Towards the monitor
    output pdr_pkg::pdr_inputs_s digIn,
    output logic signed [15:0] powerEst,
    output logic [15:0] speedEst
);
    import pdr_pkg::*;
    logic [11:0] lines;
    // Switch closes on flow, so a broken wire reads as dry
    always_comb begin
        lines = {12{~flowOk}};
        lines[swPos] = flowOk;
    end
    always_ff @(posedge sys_clk) begin
        digIn <= '{base: lines[5:0], ext: lines[11:6], extPresent: extFitted};
        powerEst <= pwrCmd;
        speedEst <= spdCmd;
    end
endmodule

// ==== sim/pump_dry_run_monitor_test.sv ====
// Purpose: Self-checking bench of the pump dry-run monitor
// Assumes: One-second tick shortened to 20 cycles; zero wait-state slave
// Notes: Every scenario is its own task and judges its own results
`timescale 1ns/100ps
module pump_dry_run_monitor_test;
    import pdr_pkg::*;
    localparam int unsigned SEC = 20;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic [31:0] hwdata = 32'h00000000;
    logic hready;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic flowOk = 1'b1;
    logic extFitted = 1'b0;
    logic [3:0] swPos = 4'h2;
    logic signed [15:0] pwrCmd = 16'sh0000;
    logic [15:0] spdCmd = 16'h0000;
    pdr_inputs_s digIn;
    logic signed [15:0] powerEst;
    logic [15:0] speedEst;
    pdr_status_s status;
    int mismatches = 0;
    int samples_checked = 0;
    int n;

    always #10 sys_clk = ~sys_clk;
    assign hready = hreadyout;

    pdr_dry_run_monitor #(.SEC_CYCLES(SEC)) dut (.sys_clk(sys_clk), .resetn(resetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .digIn(digIn), .powerEst(powerEst), .speedEst(speedEst),
        .status(status));
    pdr_drive_model model (.sys_clk(sys_clk), .flowOk(flowOk), .swPos(swPos),
        .extFitted(extFitted), .pwrCmd(pwrCmd), .spdCmd(spdCmd), .digIn(digIn),
        .powerEst(powerEst), .speedEst(speedEst));

    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge sys_clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= 1'b1;
        haddr <= a;
        do @(posedge sys_clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge sys_clk); while (hready !== 1'b1);
    endtask

    // Read data and response are taken at the edge that ends the data phase
    task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= 1'b0;
        haddr <= a;
        do @(posedge sys_clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        do @(posedge sys_clk); while (hready !== 1'b1);
        check(what, hrdata, exp);
        check("hresp", {31'h0, hresp}, 32'h0);
    endtask

    task automatic stchk(input logic [2:0] e);
        check("status", {29'h0, status}, {29'h0, e});
    endtask

    task automatic wait_st(input int idx, input logic v, input int lim);
        n = 0;
        while (status[idx] !== v && n < lim) begin
            @(posedge sys_clk);
            n++;
        end
    endtask

    task automatic t_defaults();
        rdchk("mode", OFS_MODE, 32'h0);
        rdchk("errDelayOff", OFS_ERR_DELAY, 32'h0);
        stchk(3'h0);
        wr(OFS_MODE, 32'h3);
        rdchk("modeBad", OFS_MODE, 32'h0);
        wr(OFS_MODE, {30'h0, MODE_SWITCH});
        rdchk("errDelay", OFS_ERR_DELAY, 32'h5);
        rdchk("restart", OFS_RESTART_DELAY, 32'h3C);
        rdchk("sel", OFS_SWITCH_SEL, 32'h0);
        rdchk("factorSw", OFS_FACTOR, 32'h0);
        wr(OFS_FACTOR, 32'hA);
        wr(OFS_MODE, {30'h0, MODE_POWER});
        rdchk("factor", OFS_FACTOR, 32'h46);
        rdchk("lowPower", OFS_LOW_POWER, 32'h0);
        rdchk("highPower", OFS_HIGH_POWER, 32'h0);
        rdchk("lowSpeed", OFS_LOW_SPEED, 32'h0);
        rdchk("highSpeed", OFS_HIGH_SPEED, 32'h0);
        rdchk("selPower", OFS_SWITCH_SEL, 32'h0);
        rdchk("unmapped", 8'h3C, 32'h0);
    endtask

    task automatic t_ranges();
        wr(OFS_FACTOR, 32'hC8);
        rdchk("factorMax", OFS_FACTOR, 32'h64);
        wr(OFS_LOW_SPEED, 32'h1770);
        rdchk("lowSpeedMax", OFS_LOW_SPEED, 32'h1388);
        wr(OFS_LOW_POWER, 32'hFFFF);
        rdchk("lowPowerMax", OFS_LOW_POWER, 32'h7FFF);
        wr(OFS_ERR_DELAY, 32'hFA0);
        rdchk("errDelayMax", OFS_ERR_DELAY, 32'hE10);
        wr(OFS_RESTART_DELAY, 32'h5);
        rdchk("restartMin", OFS_RESTART_DELAY, 32'hA);
        wr(OFS_RESTART_DELAY, 32'hFA0);
        rdchk("restartMax", OFS_RESTART_DELAY, 32'hE10);
    endtask

    // Curve 10.00 kW at 10.0 Hz to 30.00 kW at 50.0 Hz, factor 50 %
    task automatic t_power();
        logic [15:0] spd [7] = '{16'd300, 16'd300, 16'd500, 16'd500, 16'd50, 16'd50, 16'd300};
        logic [15:0] sensorless_power_mode [7] = '{16'd900, 16'd1100, 16'd1400, 16'd1600, 16'd400, 16'd600,
            -16'sd500};
        logic warn [7] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
        wr(OFS_LOW_POWER, 32'h3E8);
        wr(OFS_LOW_SPEED, 32'h64);
        wr(OFS_HIGH_POWER, 32'hBB8);
        wr(OFS_HIGH_SPEED, 32'h1F4);
        wr(OFS_FACTOR, 32'h32);
        for (int i = 0; i < 7; i++) begin
            spdCmd <= spd[i];
            pwrCmd <= sensorless_power_mode[i];
            cyc(6);
            stchk({warn[i], 2'b00});
        end
        rdchk("powerEst", OFS_POWER_EST, 32'hFFFFFE0C);
    endtask

    task automatic t_switch();
        logic [3:0] pos [7] = '{4'h2, 4'h2, 4'h2, 4'h2, 4'h7, 4'h7, 4'h2};
        logic [4:0] sel [7] = '{5'h13, 5'h13, 5'h03, 5'h03, 5'h1A, 5'h1A, 5'h00};
        logic flo [7] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
        logic ext [7] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
        logic warn [7] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
        wr(OFS_MODE, {30'h0, MODE_SWITCH});
        for (int i = 0; i < 7; i++) begin
            wr(OFS_SWITCH_SEL, {27'h0, sel[i]});
            swPos <= pos[i];
            flowOk <= flo[i];
            extFitted <= ext[i];
            cyc(4);
            stchk({warn[i], 2'b00});
        end
        rdchk("selRead", OFS_SWITCH_SEL, 32'h0);
    endtask

    task automatic t_error();
        wr(OFS_SWITCH_SEL, 32'h13);
        swPos <= 4'h2;
        wr(OFS_ERR_DELAY, 32'h2);
        wr(OFS_RESTART_DELAY, 32'hA);
        // Short dry spells must not add up to an error
        for (int i = 0; i < 3; i++) begin
            flowOk <= 1'b0;
            cyc(18);
            stchk(3'b100);
            flowOk <= 1'b1;
            cyc(3);
        end
        flowOk <= 1'b0;
        cyc(15);
        stchk(3'b100);
        wait_st(1, 1'b1, 80);
        check("errTooLate", {31'h0, n <= 50}, 32'h1);
        check("errTooEarly", {31'h0, n >= 25}, 32'h1);
        stchk(3'b111);
        flowOk <= 1'b1;
        cyc(3);
        wr(OFS_STATUS, 32'h2);
        cyc(2);
        stchk(3'b001);
        cyc(150);
        stchk(3'b001);
        wait_st(0, 1'b0, 100);
        stchk(3'b000);
    endtask

    task automatic t_powerloss();
        wr(OFS_ERR_DELAY, 32'h0);
        flowOk <= 1'b0;
        cyc(25);
        stchk(3'b111);
        resetn <= 1'b0;
        cyc(3);
        stchk(3'b000);
        resetn <= 1'b1;
        cyc(3);
        stchk(3'b000);
        rdchk("modeAfter", OFS_MODE, 32'h0);
    endtask

    initial begin
        cyc(10);
        resetn <= 1'b1;
        cyc(3);
        t_defaults();
        t_ranges();
        t_power();
        t_switch();
        t_error();
        t_powerloss();
        summarize();
    end

    initial begin
        #200us;
        mismatches++;
        summarize();
    end
endmodule
